/* File: logic/chan_switch_pkg.sv */
package chan_switch_pkg;
    // =====================================================
    // slave address
    // =====================================================
    // upper fixed address bits: value arbitrary, chosen locally
    localparam logic [3:0] ADDR_FIXED = 4'hE;
    // =====================================================
    // control byte layout
    // =====================================================
    localparam int SEL_LOW_POS = 0;
    localparam int SEL_HIGH_POS = 1;
    localparam int SEL_EN_POS = 2;
    localparam int IRQ_LSB_POS = 4;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] NO_LANE = 4'h0;
    // =====================================================
    // serial bus timing
    // =====================================================
    localparam int CLK_MHZ = 100;
    localparam int MAX_SCL_KHZ = 400;
    localparam int SCL_PERIOD_CYCLES = CLK_MHZ * 1000 / MAX_SCL_KHZ;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

/* File: logic/chan_switch.sv */
// Summary of operation
// - upstream pair joins at most one downstream pair, chosen by control register
// - four downstream lanes, each clock and data, any one switchable upstream
// - interrupt output is the AND of the four active-low lane inputs
// - reset clears control register and bus state, all lanes disconnected
// - last address bit one means read, zero means write
// - after address acknowledge, written data byte goes into control register
// - several written bytes: only the last one is kept
// - control register is writable and readable over the upstream bus
// - three strap inputs form the low address bits, eight devices per bus
// - each lane interrupt input is asserted when low
// - bus interface works from zero up to 400 kHz serial clock
// - bit 2 clear selects none; bit 2 set selects lane given by bits 1..0
// - new lane selection takes effect only after a stop condition
// - read returns lane interrupt states in bits 4..7, bit 4 for lane 0
module chan_switch (
    input wire logic CLOCK, // system clock, 100 MHz
    input wire logic RSTN, // asynchronous reset, active low
    input wire logic SCL_IN, // upstream clock level seen on the wire
    input wire logic SDA_IN, // upstream data level seen on the wire
    output logic SDA_OE_N, // low while the device pulls data low
    output logic SDA_OUT, // data drive value, always 0
    input wire logic [2:0] ADDR_STRAP, // addr_strap_bit_two..zero
    input wire logic [3:0] IRQ_LANE_N, // irq_lane_three_n..zero_n
    output logic IRQ_OUT_N, // combined interrupt, active low
    output logic [3:0] LANE_CONNECT // one-hot connection enable, bit n for lane n
);
    typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WR_DATA, WR_ACK, RD_DATA, RD_ACK}
        state_t;

    // =====================================================
    // input synchronisers
    // =====================================================
    logic [1:0] scl_sync_q, sda_sync_q;
    logic [2:0] strap_s1_q, strap_s2_q;
    logic [3:0] irq_s1_q, irq_s2_q;
    logic scl_prev_q, sda_prev_q;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            irq_s1_q <= 4'hF;
            irq_s2_q <= 4'hF;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], SCL_IN};
            sda_sync_q <= {sda_sync_q[0], SDA_IN};
            strap_s1_q <= ADDR_STRAP;
            strap_s2_q <= strap_s1_q;
            irq_s1_q <= IRQ_LANE_N;
            irq_s2_q <= irq_s1_q;
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    wire scl = scl_sync_q[1];
    wire sda = sda_sync_q[1];
    wire scl_rise = scl && !scl_prev_q;
    wire scl_fall = !scl && scl_prev_q;
    wire start_seen = scl && scl_prev_q && sda_prev_q && !sda;
    wire stop_seen = scl && scl_prev_q && !sda_prev_q && sda;

    // =====================================================
    // byte engine
    // =====================================================
    state_t state_q, state_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic pend_q, pend_d;
    logic full_q, full_d; // eight bits of the current byte are in
    logic [3:0] lane_q, lane_d;
    logic oe_n_q, oe_n_d;

    wire [7:0] rx_byte = {shift_q[6:0], sda};
    wire addr_hit = shift_q[7:1] == {chan_switch_pkg::ADDR_FIXED, strap_s2_q};
    wire [7:0] rd_byte = {irq_s2_q, 1'b0, ctrl_q};
    wire [3:0] lane_dec = ctrl_q[chan_switch_pkg::SEL_EN_POS] ?
        4'h1 << ctrl_q[chan_switch_pkg::SEL_HIGH_POS:chan_switch_pkg::SEL_LOW_POS] :
        chan_switch_pkg::NO_LANE;

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ctrl_d = ctrl_q;
        pend_d = pend_q;
        full_d = full_q;
        lane_d = lane_q;
        oe_n_d = oe_n_q;
        if (stop_seen) begin
            state_d = IDLE;
            oe_n_d = 1'b1;
            if (pend_q) begin
                lane_d = lane_dec;
                pend_d = 1'b0;
            end
        end else if (start_seen) begin
            state_d = ADDR;
            bit_d = 3'h0;
            full_d = 1'b0;
            oe_n_d = 1'b1;
        end else begin
            case (state_q)
                IDLE: oe_n_d = 1'b1;
                ADDR, WR_DATA: begin
                    if (scl_rise) begin
                        shift_d = rx_byte;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == chan_switch_pkg::BIT_LAST) begin
                            full_d = 1'b1;
                        end
                    end
                    // a byte is taken on the falling edge after its eighth bit
                    if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        if (state_q == ADDR) begin
                            if (addr_hit) begin
                                state_d = ADDR_ACK;
                                oe_n_d = 1'b0;
                            end else begin
                                state_d = IDLE;
                            end
                        end else begin
                            ctrl_d = shift_q[2:0];
                            pend_d = 1'b1;
                            state_d = WR_ACK;
                            oe_n_d = 1'b0;
                        end
                    end
                end
                ADDR_ACK, WR_ACK: begin
                    if (scl_fall) begin
                        bit_d = 3'h0;
                        shift_d = 8'h0;
                        if (state_q == ADDR_ACK && shift_q[0]) begin
                            state_d = RD_DATA;
                            shift_d = rd_byte;
                            oe_n_d = rd_byte[7];
                        end else begin
                            state_d = WR_DATA;
                            oe_n_d = 1'b1;
                        end
                    end
                end
                RD_DATA: begin
                    if (scl_fall) begin
                        if (bit_q == chan_switch_pkg::BIT_LAST) begin
                            state_d = RD_ACK;
                            oe_n_d = 1'b1;
                        end else begin
                            bit_d = bit_q + 3'h1;
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_n_d = shift_q[6];
                        end
                    end
                end
                RD_ACK: begin
                    // master not acknowledging ends the read
                    if (scl_rise && sda) begin
                        state_d = IDLE;
                    end
                    // acknowledged: next byte drives its first bit from this falling edge
                    if (scl_fall) begin
                        state_d = RD_DATA;
                        bit_d = 3'h0;
                        shift_d = rd_byte;
                        oe_n_d = rd_byte[7];
                    end
                end
                default: state_d = IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h0;
            ctrl_q <= chan_switch_pkg::CTRL_RESET;
            pend_q <= 1'b0;
            lane_q <= chan_switch_pkg::NO_LANE;
            oe_n_q <= 1'b1;
            full_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            lane_q <= lane_d;
            oe_n_q <= oe_n_d;
            full_q <= full_d;
        end
    end

    // =====================================================
    // outputs
    // =====================================================
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = oe_n_q;
    assign LANE_CONNECT = lane_q;
    assign IRQ_OUT_N = &irq_s2_q;
endmodule

/* File: tb/bus_master.sv */
module bus_master (
    output logic scl, // upstream clock, idles high
    output logic sda_o, // 1 releases data, 0 pulls low
    input wire logic sda // resolved data wire
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    // =====================================================
    // bus conditions and bits
    // =====================================================
    task automatic start();
        sda_o = 1'b0;
        #80 scl = 1'b0;
    endtask
    task automatic stop();
        #40 sda_o = 1'b0;
        #40 scl = 1'b1;
        #80 sda_o = 1'b1;
        #80;
    endtask
    task automatic clk_bit(input logic b, output logic s);
        #40 sda_o = b;
        #40 scl = 1'b1;
        #80 s = sda;
        scl = 1'b0;
    endtask
    // msb first, ninth bit always released by the master
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(1'b1, ack);
    endtask
endmodule

/* File: tb/chan_switch_checker.sv */
module chan_switch_checker (
    input wire logic CLOCK, // clock
    input wire logic RSTN, // reset
    input wire logic SCL_IN, // bus clock
    input wire logic SDA_IN, // bus data
    input wire logic SDA_OE_N, // data drive
    input wire logic SDA_OUT, // drive value
    input wire logic [2:0] ADDR_STRAP, // straps
    input wire logic [3:0] IRQ_LANE_N, // lane irqs
    input wire logic IRQ_OUT_N, // combined irq
    input wire logic [3:0] LANE_CONNECT // lanes
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    logic sda_q;
    logic [3:0] since_stop_q;
    // =====================================================
    // cycles since the last stop on the wire
    // =====================================================
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sda_q <= 1'b1;
            since_stop_q <= 4'hF;
        end else begin
            sda_q <= SDA_IN;
            if (SCL_IN && SDA_IN && !sda_q) since_stop_q <= 4'h0;
            else if (since_stop_q != 4'hF) since_stop_q <= since_stop_q + 4'h1;
        end
    end
    AST_ONE_LANE: assert property ($onehot0(LANE_CONNECT)) else $error("two lanes");
    AST_IRQ_AND: assert property ($stable(IRQ_LANE_N) [*6] |-> IRQ_OUT_N == &IRQ_LANE_N)
        else $error("irq output not and of inputs");
    AST_RESET_CLEAR: assert property ($rose(RSTN) |-> LANE_CONNECT == 4'h0 && SDA_OE_N && IRQ_OUT_N)
        else $error("reset state wrong");
    AST_LANE_AT_STOP: assert property ($changed(LANE_CONNECT) |-> since_stop_q < 4'hC)
        else $error("lane changed away from stop");
    AST_SDA_OUT_ZERO: assert property (SDA_OUT == 1'b0) else $error("data drive not low");
    AST_ACK_LOW_PHASE: assert property ($fell(SDA_OE_N) |-> !SCL_IN && !$past(SCL_IN, 2))
        else $error("drive began in clock high");
    AST_RELEASE_IN_TIME: assert property ($fell(SDA_OE_N) |-> ##[1:200] SDA_OE_N)
        else $error("data not released");
    AST_OE_STABLE_HIGH: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_N))
        else $error("drive changed in clock high");
endmodule
bind chan_switch chan_switch_checker chan_switch_checker_i (.CLOCK(CLOCK), .RSTN(RSTN),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OE_N(SDA_OE_N), .SDA_OUT(SDA_OUT),
    .ADDR_STRAP(ADDR_STRAP), .IRQ_LANE_N(IRQ_LANE_N), .IRQ_OUT_N(IRQ_OUT_N),
    .LANE_CONNECT(LANE_CONNECT));

/* File: tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [3:0] irq = 4'hF;
    logic scl, sda_m, sda_oe_n, sda_out, irq_out_n, ack;
    logic [3:0] lane, exp_lane;
    logic [7:0] res, rx, v, rnd;
    wire sda = sda_m & (sda_oe_n | sda_out);
    string nm;
    event res_ev;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    int miscompares = 0;
    int tests_run = 0;
    always #5 CLOCK = ~CLOCK;
    chan_switch chan_switch_i (.CLOCK(CLOCK), .RSTN(RSTN), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OE_N(sda_oe_n), .SDA_OUT(sda_out), .ADDR_STRAP(strap), .IRQ_LANE_N(irq),
        .IRQ_OUT_N(irq_out_n), .LANE_CONNECT(lane));
    bus_master bus_master_i (.scl(scl), .sda_o(sda_m), .sda(sda));
    // =====================================================
    // checking
    // =====================================================
    task automatic stop_test();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
        exp_q.push_back(e);
        nm = n;
        res = s;
        ->res_ev;
        #1;
    endtask
    always @(res_ev) begin
        tests_run++;
        exp_v = exp_q.pop_front();
        if (exp_v !== res) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp_v, res);
        end
    end
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
    // =====================================================
    // write, apply at stop, read back for every selection
    // =====================================================
    initial begin
        void'($urandom(32'h381020c1));
        exp_lane = 4'h0;
        repeat (16) @(posedge CLOCK);
        #1 RSTN = 1'b1;
        check("lane", 8'h00, {4'h0, lane});
        check("irq", 8'h01, {7'h0, irq_out_n});
        for (int i = 0; i < 9; i++) begin
            v = {5'($urandom), i[2:0]};
            rnd = 8'($urandom);
            strap = 3'($urandom);
            irq = 4'($urandom);
            repeat (4) @(posedge CLOCK);
            #1 bus_master_i.start();
            bus_master_i.xfer({chan_switch_pkg::ADDR_FIXED, strap ^ {2'h0, i == 8}, 1'b0}, rx, ack);
            check("addr ack", {7'h0, i == 8}, {7'h0, ack});
            bus_master_i.xfer(rnd, rx, ack);
            check("data ack", {7'h0, i == 8}, {7'h0, ack});
            bus_master_i.xfer(v, rx, ack);
            check("data ack", {7'h0, i == 8}, {7'h0, ack});
            check("lane before stop", {4'h0, exp_lane}, {4'h0, lane});
            bus_master_i.stop();
            repeat (8) @(posedge CLOCK);
            #1 if (i < 8) exp_lane = v[2] ? 4'h1 << v[1:0] : 4'h0;
            check("lane", {4'h0, exp_lane}, {4'h0, lane});
            check("irq", {7'h0, &irq}, {7'h0, irq_out_n});
            bus_master_i.start();
            bus_master_i.xfer({chan_switch_pkg::ADDR_FIXED, strap, 1'b1}, rx, ack);
            check("read addr ack", 8'h00, {7'h0, ack});
            bus_master_i.xfer(8'hFF, rx, ack);
            bus_master_i.stop();
            check("read", {irq, 1'b0, (i < 8) ? v[2:0] : 3'(i - 1)}, rx);
        end
        stop_test();
    end
endmodule
